// File: design/stc_pkg.sv
// constants for the synthesizer and timestamp configuration registers
package stc_pkg;
   localparam int STC_ADDR_W = 15;
   localparam int STC_DATA_W = 8;
   localparam int STC_FRAME_BITS = 24;
   localparam int STC_NUM_REGS = 6;
   localparam int STC_NUM_LANES = 8;
   // register offsets
   localparam logic [14:0] STC_OFS_STAMP = 15'h003B;
   localparam logic [14:0] STC_OFS_REFOUT = 15'h003C;
   localparam logic [14:0] STC_OFS_DIV_PV = 15'h003D;
   localparam logic [14:0] STC_OFS_DIV_N = 15'h003E;
   localparam logic [14:0] STC_OFS_BIAS = 15'h003F;
   localparam logic [14:0] STC_OFS_PREEMPH = 15'h0048;
   // register indices
   localparam logic [2:0] STC_IDX_STAMP = 3'h0;
   localparam logic [2:0] STC_IDX_REFOUT = 3'h1;
   localparam logic [2:0] STC_IDX_DIV_PV = 3'h2;
   localparam logic [2:0] STC_IDX_DIV_N = 3'h3;
   localparam logic [2:0] STC_IDX_BIAS = 3'h4;
   localparam logic [2:0] STC_IDX_PREEMPH = 3'h5;
   localparam logic [2:0] STC_IDX_NONE = 3'h7;
   // reset values
   localparam logic [7:0] STC_RST_STAMP = 8'h00;
   localparam logic [7:0] STC_RST_REFOUT = 8'h01;
   localparam logic [7:0] STC_RST_DIV_PV = 8'h00;
   localparam logic [7:0] STC_RST_DIV_N = 8'h20;
   localparam logic [7:0] STC_RST_BIAS = 8'h4F;
   localparam logic [7:0] STC_RST_PREEMPH = 8'h00;
   localparam logic [7:0] STC_RD_UNMAPPED = 8'h00;
   // field positions
   localparam int STC_BIT_RECV_ON = 0;
   localparam int STC_BIT_PECL = 1;
   localparam int STC_BIT_REFOUT_ON = 0;
   localparam int STC_P_LSB = 2;
   localparam int STC_V_LSB = 0;
   localparam int STC_N_LSB = 0;
   localparam int STC_N_W = 6;
   localparam int STC_BIAS_LSB = 0;
   localparam int STC_BIAS_W = 7;
   localparam int STC_PE_LSB = 0;
   localparam int STC_PE_W = 4;
   // divider ratios, zero marks a reserved code
   localparam logic [2:0] STC_P_RATIO_0 = 3'h1;
   localparam logic [2:0] STC_P_RATIO_1 = 3'h2;
   localparam logic [2:0] STC_P_RATIO_2 = 3'h4;
   localparam logic [2:0] STC_V_RATIO_0 = 3'h5;
   localparam logic [2:0] STC_V_RATIO_1 = 3'h4;
   localparam logic [2:0] STC_V_RATIO_2 = 3'h3;
   localparam logic [2:0] STC_RATIO_BAD = 3'h0;
endpackage : stc_pkg

// File: design/stc_cfg_if.sv
// register access signals between serial port and register file
`timescale 1ns/1ns
`default_nettype none
interface stc_cfg_if;
   logic wr_stb;
   logic [14:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport port (output wr_stb, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : stc_cfg_if
`default_nettype wire

// File: design/stc_serial_port.sv
// serial configuration port: 1 r/w bit, 15 address bits, 8 data bits, msb first
`timescale 1ns/1ns
`default_nettype none
module stc_serial_port
   import stc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // serial pins
   input wire logic sclk_i,
   input wire logic cs_b_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // register side
   stc_cfg_if.port cfg
);
   logic sclk_q_r;
   logic [22:0] shift_r;
   logic [4:0] cnt_r;
   logic rw_r;
   logic [14:0] addr_r;
   logic [7:0] wdata_r;
   logic wr_r;
   logic sdo_r;
   logic sdo_oe_r;
   wire rise = sclk_i & ~sclk_q_r;
   wire fall = ~sclk_i & sclk_q_r;
   wire [4:0] last_cnt = 5'(STC_FRAME_BITS - 1);
   wire [4:0] addr_cnt = 5'(STC_ADDR_W);
   wire data_phase = (cnt_r > addr_cnt) && (cnt_r <= last_cnt);
   wire [2:0] out_idx = 3'(last_cnt - cnt_r);
   wire last_bit = rise && (cnt_r == last_cnt);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_q_r <= 1'b0;
         shift_r <= '0;
         cnt_r <= 5'h00;
         rw_r <= 1'b0;
         addr_r <= 15'h0000;
         wdata_r <= 8'h00;
         wr_r <= 1'b0;
         sdo_r <= 1'b0;
         sdo_oe_r <= 1'b0;
      end else begin
         sclk_q_r <= sclk_i;
         wr_r <= 1'b0;
         if (cs_b_i) begin
            cnt_r <= 5'h00;
            sdo_oe_r <= 1'b0;
         end else begin
            if (rise && (cnt_r <= last_cnt)) begin
               shift_r <= {shift_r[21:0], sdi_i};
               cnt_r <= cnt_r + 5'h01;
            end
            if (rise && (cnt_r == addr_cnt)) begin
               rw_r <= shift_r[14];
               addr_r <= {shift_r[13:0], sdi_i};
            end
            if (last_bit && !rw_r) begin
               wdata_r <= {shift_r[6:0], sdi_i};
               wr_r <= 1'b1;
            end
            if (fall && rw_r && data_phase) begin
               sdo_r <= cfg.rdata[out_idx];
               sdo_oe_r <= 1'b1;
            end
         end
      end
   end

   assign cfg.wr_stb = wr_r;
   assign cfg.addr = addr_r;
   assign cfg.wdata = wdata_r;
   assign sdo_o = sdo_r;
   assign sdo_oe_o = sdo_oe_r;
endmodule : stc_serial_port
`default_nettype wire

// File: design/stc_synth_stamp_regs.sv
// synthesizer and timestamp configuration registers with serial access
`timescale 1ns/1ns
`default_nettype none
module stc_synth_stamp_regs
   import stc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // serial configuration port
   input wire logic sclk_i,
   input wire logic cs_b_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // synthesizer enable pin
   input wire logic synth_enable_i,
   // timestamp input receiver
   output logic stamp_receiver_on_o,
   output logic stamp_pecl_select_o,
   output logic stamp_selfbias_on_o,
   // reference output
   output logic synth_reference_output_on_o,
   // synthesizer settings
   output logic [2:0] p_div_ratio_o,
   output logic [2:0] v_div_ratio_o,
   output logic [5:0] n_div_ratio_o,
   output logic [6:0] oscillator_bias_level_o,
   // lane pre-emphasis
   output logic [31:0] lane_preemphasis_level_o
);
   localparam logic [7:0] RST_VALS [STC_NUM_REGS] = '{STC_RST_STAMP, STC_RST_REFOUT, STC_RST_DIV_PV,
                                                      STC_RST_DIV_N, STC_RST_BIAS, STC_RST_PREEMPH};

   stc_cfg_if cfg ();

   stc_serial_port u_port (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .sclk_i(sclk_i),
      .cs_b_i(cs_b_i),
      .sdi_i(sdi_i),
      .sdo_o(sdo_o),
      .sdo_oe_o(sdo_oe_o),
      .cfg(cfg.port)
   );

   logic [7:0] regs_r [STC_NUM_REGS];
   logic stamp_on_r;
   logic pecl_r;
   logic selfbias_r;
   logic refout_r;
   logic [2:0] p_ratio_r;
   logic [2:0] v_ratio_r;
   logic [5:0] n_ratio_r;
   logic [6:0] bias_r;
   logic [31:0] pe_r;

   // offset matches
   wire hit_stamp = (cfg.addr == STC_OFS_STAMP);
   wire hit_refout = (cfg.addr == STC_OFS_REFOUT);
   wire hit_div_pv = (cfg.addr == STC_OFS_DIV_PV);
   wire hit_div_n = (cfg.addr == STC_OFS_DIV_N);
   wire hit_bias = (cfg.addr == STC_OFS_BIAS);
   wire hit_preemph = (cfg.addr == STC_OFS_PREEMPH);

   // address decode
   wire [2:0] sel_idx = hit_stamp ? STC_IDX_STAMP :
                        hit_refout ? STC_IDX_REFOUT :
                        hit_div_pv ? STC_IDX_DIV_PV :
                        hit_div_n ? STC_IDX_DIV_N :
                        hit_bias ? STC_IDX_BIAS :
                        hit_preemph ? STC_IDX_PREEMPH : STC_IDX_NONE;
   wire hit = (sel_idx != STC_IDX_NONE);
   wire wr_en = cfg.wr_stb && hit;
   assign cfg.rdata = hit ? regs_r[sel_idx] : STC_RD_UNMAPPED;

   // register storage, full byte kept so reserved bits read back
   genvar gi;
   generate
      for (gi = 0; gi < STC_NUM_REGS; gi++) begin : g_reg
         wire wr_this = wr_en && (sel_idx == 3'(gi));
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               regs_r[gi] <= RST_VALS[gi];
            end else if (wr_this) begin
               regs_r[gi] <= cfg.wdata;
            end
         end
      end
   endgenerate

   // field extraction
   wire [7:0] stamp_reg = regs_r[STC_IDX_STAMP];
   wire [7:0] refout_reg = regs_r[STC_IDX_REFOUT];
   wire [7:0] pv_reg = regs_r[STC_IDX_DIV_PV];
   wire [1:0] p_code = pv_reg[STC_P_LSB +: 2];
   wire [1:0] v_code = pv_reg[STC_V_LSB +: 2];
   wire [2:0] p_dec = (p_code == 2'h0) ? STC_P_RATIO_0 :
                      (p_code == 2'h1) ? STC_P_RATIO_1 :
                      (p_code == 2'h2) ? STC_P_RATIO_2 : STC_RATIO_BAD;
   wire [2:0] v_dec = (v_code == 2'h0) ? STC_V_RATIO_0 :
                      (v_code == 2'h1) ? STC_V_RATIO_1 :
                      (v_code == 2'h2) ? STC_V_RATIO_2 : STC_RATIO_BAD;
   wire [3:0] pe_level = regs_r[STC_IDX_PREEMPH][STC_PE_LSB +: STC_PE_W];
   wire [31:0] pe_fan;

   generate
      for (gi = 0; gi < STC_NUM_LANES; gi++) begin : g_lane
         assign pe_fan[gi*STC_PE_W +: STC_PE_W] = pe_level;
      end
   endgenerate

   // next values of the control outputs
   wire stamp_on_nxt = stamp_reg[STC_BIT_RECV_ON];
   wire pecl_nxt = stamp_reg[STC_BIT_PECL];
   wire selfbias_nxt = ~stamp_reg[STC_BIT_PECL];
   wire refout_nxt = refout_reg[STC_BIT_REFOUT_ON] & synth_enable_i;
   wire [2:0] p_ratio_nxt = p_dec;
   wire [2:0] v_ratio_nxt = v_dec;
   wire [5:0] n_ratio_nxt = regs_r[STC_IDX_DIV_N][STC_N_LSB +: STC_N_W];
   wire [6:0] bias_nxt = regs_r[STC_IDX_BIAS][STC_BIAS_LSB +: STC_BIAS_W];
   wire [31:0] pe_nxt = pe_fan;

   // timestamp receiver enable
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stamp_on_r <= STC_RST_STAMP[STC_BIT_RECV_ON];
      end else begin
         stamp_on_r <= stamp_on_nxt;
      end
   end

   // pecl mode select
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pecl_r <= STC_RST_STAMP[STC_BIT_PECL];
      end else begin
         pecl_r <= pecl_nxt;
      end
   end

   // common-mode self-bias, off in pecl mode
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         selfbias_r <= ~STC_RST_STAMP[STC_BIT_PECL];
      end else begin
         selfbias_r <= selfbias_nxt;
      end
   end

   // reference output, gated by the pin
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         refout_r <= 1'b0;
      end else begin
         refout_r <= refout_nxt;
      end
   end

   // second divider ratio
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         p_ratio_r <= STC_P_RATIO_0;
      end else begin
         p_ratio_r <= p_ratio_nxt;
      end
   end

   // first divider ratio
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         v_ratio_r <= STC_V_RATIO_0;
      end else begin
         v_ratio_r <= v_ratio_nxt;
      end
   end

   // third divider value
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         n_ratio_r <= STC_RST_DIV_N[5:0];
      end else begin
         n_ratio_r <= n_ratio_nxt;
      end
   end

   // oscillator bias level
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bias_r <= STC_RST_BIAS[6:0];
      end else begin
         bias_r <= bias_nxt;
      end
   end

   // pre-emphasis level, one value copied to all 8 lanes
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pe_r <= 32'h00000000;
      end else begin
         pe_r <= pe_nxt;
      end
   end

   assign stamp_receiver_on_o = stamp_on_r;
   assign stamp_pecl_select_o = pecl_r;
   assign stamp_selfbias_on_o = selfbias_r;
   assign synth_reference_output_on_o = refout_r;
   assign p_div_ratio_o = p_ratio_r;
   assign v_div_ratio_o = v_ratio_r;
   assign n_div_ratio_o = n_ratio_r;
   assign oscillator_bias_level_o = bias_r;
   assign lane_preemphasis_level_o = pe_r;
endmodule : stc_synth_stamp_regs
`default_nettype wire

// File: testbench/stc_regs_chk.sv
// assertion checker for the synthesizer and timestamp registers
`timescale 1ns/1ns
`default_nettype none
module stc_regs_chk (
   // clock, reset, pins
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic cs_b_i,
   input wire logic synth_enable_i,
   // outputs watched
   input wire logic sdo_oe_o,
   input wire logic stamp_receiver_on_o,
   input wire logic stamp_pecl_select_o,
   input wire logic stamp_selfbias_on_o,
   input wire logic synth_reference_output_on_o,
   input wire logic [2:0] p_div_ratio_o,
   input wire logic [2:0] v_div_ratio_o,
   input wire logic [5:0] n_div_ratio_o,
   input wire logic [6:0] oscillator_bias_level_o,
   input wire logic [31:0] lane_preemphasis_level_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   a_selfbias_inverse: assert property (stamp_selfbias_on_o == !stamp_pecl_select_o)
      else $error("selfbias wrong");
   a_refout_needs_pin: assert property (synth_reference_output_on_o |-> $past(synth_enable_i))
      else $error("refout without pin");
   a_refout_after_reset: assert property ($rose(rst_b_i) && synth_enable_i |=> synth_reference_output_on_o)
      else $error("refout off after reset");
   a_pdiv_ratio_legal: assert property (p_div_ratio_o inside {3'h1, 3'h2, 3'h4, 3'h0})
      else $error("p ratio illegal");
   a_vdiv_ratio_legal: assert property (v_div_ratio_o inside {3'h5, 3'h4, 3'h3, 3'h0})
      else $error("v ratio illegal");
   a_lanes_all_equal: assert property (lane_preemphasis_level_o == {8{lane_preemphasis_level_o[3:0]}})
      else $error("lanes differ");
   a_reset_values: assert property ($rose(rst_b_i) |-> n_div_ratio_o == 6'h20
      && oscillator_bias_level_o == 7'h4F && p_div_ratio_o == 3'h1 && v_div_ratio_o == 3'h5 && !stamp_receiver_on_o)
      else $error("reset value wrong");
   a_idle_regs_hold: assert property (cs_b_i [*5] |-> $stable({stamp_receiver_on_o, p_div_ratio_o,
      v_div_ratio_o, n_div_ratio_o, oscillator_bias_level_o, lane_preemphasis_level_o}))
      else $error("setting changed while idle");
   a_sdo_released: assert property (cs_b_i [*3] |-> !sdo_oe_o)
      else $error("sdo driven while idle");
endmodule : stc_regs_chk
bind stc_synth_stamp_regs stc_regs_chk u_chk (.*);
`default_nettype wire

// File: testbench/stc_synth_stamp_regs_tb.sv
// self-checking bench for the synthesizer and timestamp registers
`timescale 1ns/1ns
`default_nettype none
module stc_synth_stamp_regs_tb
   import stc_pkg::*;
;
   logic clk_i, rst_b_i, sclk_i, cs_b_i, sdi_i, synth_enable_i, sdo_o, sdo_oe_o;
   logic stamp_receiver_on_o, stamp_pecl_select_o, stamp_selfbias_on_o, synth_reference_output_on_o;
   logic [2:0] p_div_ratio_o, v_div_ratio_o;
   logic [5:0] n_div_ratio_o;
   logic [6:0] oscillator_bias_level_o;
   logic [31:0] lane_preemphasis_level_o;
   logic [7:0] q;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [14:0] ofs [6] = '{STC_OFS_STAMP, STC_OFS_REFOUT, STC_OFS_DIV_PV, STC_OFS_DIV_N, STC_OFS_BIAS, STC_OFS_PREEMPH};
   logic [7:0] rv [6] = '{STC_RST_STAMP, STC_RST_REFOUT, STC_RST_DIV_PV, STC_RST_DIV_N, STC_RST_BIAS, STC_RST_PREEMPH};
   logic [2:0] pexp [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
   logic [2:0] vexp [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
   wire logic [2:0] stamp = {stamp_receiver_on_o, stamp_pecl_select_o, stamp_selfbias_on_o};
   stc_synth_stamp_regs u_dut (.*);
   task automatic give_verdict();
      if (bad_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s exp %0h got %0h", nm, exp, got);
      end
   endtask : check
   // one frame: r/w bit, 15 address bits, 8 data bits, msb first
   task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] d, output logic [7:0] r);
      logic [23:0] f;
      f = {rw, a, d};
      cs_b_i = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(negedge clk_i) sdi_i = f[i];
         @(negedge clk_i);
         if (i < 8) r[i] = sdo_o;
         if (i < 8 && rw) check("sdo_oe", 1'b1, sdo_oe_o);
         sclk_i = 1'b1;
         repeat (2) @(negedge clk_i);
         sclk_i = 1'b0;
      end
      repeat (4) @(negedge clk_i);
      cs_b_i = 1'b1;
      repeat (6) @(negedge clk_i);
   endtask : xfer
   task automatic rdchk(input string nm, input logic [14:0] a, input logic [7:0] e);
      logic [7:0] r;
      xfer(1'b1, a, 8'h00, r);
      check(nm, e, r);
   endtask : rdchk
   task automatic do_reset();
      rst_b_i = 1'b0;
      repeat (6) @(negedge clk_i);
      rst_b_i = 1'b1;
      @(negedge clk_i);
   endtask : do_reset
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 10000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      rst_b_i = 1'b0;
      sclk_i = 1'b0;
      cs_b_i = 1'b1;
      sdi_i = 1'b0;
      synth_enable_i = 1'b1;
      do_reset();
      check("refout", 1'b1, synth_reference_output_on_o);
      foreach (ofs[k]) rdchk("reset", ofs[k], rv[k]);
      xfer(1'b0, 15'h0040, 8'h5A, q);
      rdchk("unmapped", 15'h0040, 8'h00);
      for (int d = 0; d < 4; d++) begin
         xfer(1'b0, STC_OFS_STAMP, 8'(d), q);
         check("stamp", {d[0], d[1], !d[1]}, stamp);
      end
      for (int k = 0; k < 4; k++) begin
         synth_enable_i = k[1];
         xfer(1'b0, STC_OFS_REFOUT, {7'h00, k[0]}, q);
         check("refout", k == 3, synth_reference_output_on_o);
      end
      for (int c = 0; c < 4; c++) begin
         xfer(1'b0, STC_OFS_DIV_PV, 8'(c * 5), q);
         check("pdiv", pexp[c], p_div_ratio_o);
         check("vdiv", vexp[c], v_div_ratio_o);
      end
      xfer(1'b0, STC_OFS_DIV_N, 8'h3F, q);
      check("ndiv", 6'h3F, n_div_ratio_o);
      xfer(1'b0, STC_OFS_DIV_N, 8'h01, q);
      check("ndiv", 6'h01, n_div_ratio_o);
      xfer(1'b0, STC_OFS_BIAS, 8'h4A, q);
      check("bias", 7'h4A, oscillator_bias_level_o);
      xfer(1'b0, STC_OFS_PREEMPH, 8'h0A, q);
      check("lanes", {8{4'hA}}, lane_preemphasis_level_o);
      rdchk("bias", STC_OFS_BIAS, 8'h4A);
      do_reset();
      foreach (ofs[k]) rdchk("reset", ofs[k], rv[k]);
      give_verdict();
   end
endmodule : stc_synth_stamp_regs_tb
`default_nettype wire
